// ==== hw/phy_port_pages_regs.vh ====
// register indices, field positions, reset values and timing counts for the
// port status and identification pages of the three-port physical layer.
// assumes a 50 MHz clock and one 32-bit aligned bus word per register index.
`ifndef PHY_PORT_PAGES_REGS_VH
`define PHY_PORT_PAGES_REGS_VH

// register indices; byte address is four times the index
`define IDX_EVENT_STATUS   4'h5
`define IDX_PAGE_PORT_SEL  4'h7
`define IDX_LINE_STATUS    4'h8
`define IDX_SPEED_FAULT    4'h9
`define IDX_MAKER_HIGH     4'ha
`define IDX_MAKER_MID      4'hb
`define IDX_MAKER_LOW      4'hc
`define IDX_PART_HIGH      4'hd
`define IDX_PART_MID       4'he
`define IDX_PART_LOW       4'hf

// page codes
`define PAGE_PORT_STATUS   3'h0
`define PAGE_IDENT         3'h1

// base register seven layout
`define SEL_PAGE_HI        7
`define SEL_PAGE_LO        5
`define SEL_PORT_HI        3
`define SEL_PORT_LO        0
`define PAGE_SEL_RST       3'h0
`define PORT_SEL_RST       4'h0

// line status register layout
`define LS_PAIR_A_HI       7
`define LS_PAIR_A_LO       6
`define LS_PAIR_B_HI       5
`define LS_PAIR_B_LO       4
`define LS_CHILD           3
`define LS_CONNECTED       2
`define LS_BIAS            1
`define LS_DISABLE         0

// speed, event enable and fault register layout
`define SF_SPEED_HI        7
`define SF_SPEED_LO        5
`define SF_EVENT_EN        4
`define SF_FAULT           3

// event status register layout
`define EV_PORT_EVENT      0

// line state codes
`define LINE_INVALID       2'h0
`define LINE_ARB_ONE       2'h1
`define LINE_ARB_ZERO      2'h2
`define LINE_HIGH_Z        2'h3

// peer speed codes
`define SPEED_S100         3'h0
`define SPEED_S200         3'h1
`define SPEED_S400         3'h2
`define SPEED_INVALID      3'h7

`define PORT_COUNT         3
`define COMPLIANCE_LEVEL   8'h01

// timing
// 330 ms and 41.6 us at 20 ns a cycle, sized to the debounce counter
`define CON_DEBOUNCE_CYC   25'hfbc520
`define BIAS_DEBOUNCE_CYC  25'h820
`define DEB_CNT_W          25

// axi responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ==== hw/stable_debounce.v ====
// level debouncer: the output rises only after the input has stayed high for
// a full stable interval and drops at once when the input falls.
// assumes the raw level is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "phy_port_pages_regs.vh"

module stable_debounce #(
  parameter [`DEB_CNT_W-1:0] STABLE_CYCLES = 25'd1
) (
  // clock and reset
  input  wire clk,
  input  wire arst_n,
  // level in and out
  input  wire raw_in,
  output reg  stable_reg
);

  reg [`DEB_CNT_W-1:0] cnt_reg;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg    <= {`DEB_CNT_W{1'b0}};
      stable_reg <= 1'b0;
    end else if (!raw_in) begin
      // a single low cycle restarts the whole interval
      cnt_reg    <= {`DEB_CNT_W{1'b0}};
      stable_reg <= 1'b0;
    end else if (!stable_reg) begin
      if (cnt_reg >= STABLE_CYCLES - 25'd1) begin
        stable_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 25'd1;
      end
    end
  end

endmodule
`default_nettype wire

// ==== hw/phy_port_status_pages.v ====
// paged status window of a three-port cable physical layer, reached by an
// axi4-lite slave: base select register, port status page, identification
// page and a port event flag. assumes all inputs are synchronous to clk.
//
// Function
// [R1] controller writes page zero and port number into base register seven
// [R2] unimplemented selected port reads zero on every port status register
// [R3] pair a field: 11 high-z, 01 arb one, 10 arb zero, 00 invalid
// [R4] pair b field uses the same four codes as pair a
// [R5] child flag 1 child, 0 parent; idle ports and pre-tree-id read child
// [R6] connected set after 330 ms stable; hardware reset clears, bus reset not
// [R7] connected means peer attached only, not that the port is active
// [R8] bias flag set only after bias stable about 41.6 to 52 us
// [R9] disable bit writes disable port; hardware reset clears; bus reset keeps
// [R10] peer speed 000/001/010 for 100/200/400; nothing above 400 detected
// [R11] peer speed reads invalid after bus reset until self-id completes
// [R12] event enable lets port events set the event flag and notify link
// [R13] resume or suspend fault sets fault bit and leaves port suspended
// [R14] resume fault lacks incoming bias; suspend fault still sees bias
// [R15] fault bit clears on write one; write zero keeps; hardware reset clears
// [R16] controller writes one to page select to reach identification page
// [R17] ident page: compliance, reserved, three maker, three part bytes
// [R18] page select picks page at addresses 8 to 15; bus reset keeps it
// [R19] event flag set on connected, bias, disable or fault change if enabled
// [R20] ports numbered from zero in four-bit port select, reset to zero
// [R21] reserved bits and addresses read zero and ignore writes
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "phy_port_pages_regs.vh"

module phy_port_status_pages #(
  parameter [`DEB_CNT_W-1:0] CON_DEBOUNCE_CYCLES = `CON_DEBOUNCE_CYC,
  // identification codes: arbitrary neutral values
  parameter [23:0]           MAKER_CODE          = 24'h12_34_56,
  parameter [23:0]           PART_CODE           = 24'h65_43_21
) (
  // clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // axi4-lite write address and data
  input  wire [31:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [31:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // bus state from the arbitration logic
  input  wire        bus_reset,
  input  wire        tree_id_done,
  input  wire        self_id_done,
  // per-port line receivers, one bit or field per port
  input  wire [2:0]  pair_a_valid,
  input  wire [2:0]  pair_a_high_z,
  input  wire [2:0]  pair_a_arb_bit,
  input  wire [2:0]  pair_b_valid,
  input  wire [2:0]  pair_b_high_z,
  input  wire [2:0]  pair_b_arb_bit,
  input  wire [2:0]  child_raw,
  input  wire [2:0]  connect_raw,
  input  wire [2:0]  bias_raw,
  input  wire [8:0]  peer_speed_raw,
  input  wire [2:0]  resume_check,
  input  wire [2:0]  suspend_check,
  // port control and link notification
  output reg  [2:0]  port_disable,
  output reg  [2:0]  port_hold_suspend,
  output reg         port_event_flag
);

  // axi state
  reg        aw_held_reg;
  reg        w_held_reg;
  reg [3:0]  wr_idx_reg;
  reg        wr_map_reg;
  reg [7:0]  wr_byte_reg;
  reg        wr_lane_reg;
  // register state
  reg [2:0]  page_sel_reg;
  reg [3:0]  port_sel_reg;
  reg [2:0]  pie_reg;
  reg [11:0] prev_status_reg;
  reg        tree_valid_reg;
  reg        speed_valid_reg;

  wire [2:0] con_w;
  wire [2:0] bias_w;

  // true when the 4-bit selection names an implemented port
  function port_ok;
    input [3:0] sel;
    begin
      port_ok = (sel < `PORT_COUNT);
    end
  endfunction

  // line state encoder shared by both pairs
  function [1:0] line_code;
    input valid;
    input high_z;
    input arb_bit;
    begin
      line_code = !valid  ? `LINE_INVALID :
                  high_z  ? `LINE_HIGH_Z  :
                  arb_bit ? `LINE_ARB_ONE : `LINE_ARB_ZERO;
    end
  endfunction

  // word address decode: index in bits 5:2, nothing above
  function addr_mapped;
    input [31:0] addr;
    begin
      addr_mapped = (addr[31:6] == 26'h0) &&
                    ((addr[5:2] == `IDX_EVENT_STATUS) ||
                     (addr[5:2] == `IDX_PAGE_PORT_SEL) ||
                     addr[5]);
    end
  endfunction

  // [R6] connection debounce
  // [R8] bias debounce
  genvar gi;
  generate
    for (gi = 0; gi < `PORT_COUNT; gi = gi + 1) begin : g_deb
      stable_debounce #(.STABLE_CYCLES (CON_DEBOUNCE_CYCLES)) u_con (
        .clk        (clk),
        .arst_n     (arst_n),
        .raw_in     (connect_raw[gi]),
        .stable_reg (con_w[gi])
      );
      stable_debounce #(.STABLE_CYCLES (`BIAS_DEBOUNCE_CYC)) u_bias (
        .clk        (clk),
        .arst_n     (arst_n),
        .raw_in     (bias_raw[gi]),
        .stable_reg (bias_w[gi])
      );
    end
  endgenerate

  // write channel handshakes
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire ar_take  = s_axi_arvalid & s_axi_arready;

  wire aw_held_next = (aw_held_reg | aw_take) & ~do_write;
  wire w_held_next  = (w_held_reg | w_take) & ~do_write;
  wire bvalid_next  = (s_axi_bvalid & ~s_axi_bready) | do_write;
  wire rvalid_next  = (s_axi_rvalid & ~s_axi_rready) | ar_take;

  // qualified register writes; byte lane zero carries every field
  wire wr_ok    = do_write & wr_map_reg & wr_lane_reg;
  wire [1:0] wp = port_sel_reg[1:0];
  wire wr_port  = port_ok(port_sel_reg) &&
                  (page_sel_reg == `PAGE_PORT_STATUS);
  wire wr_line  = wr_ok & wr_port & (wr_idx_reg == `IDX_LINE_STATUS);
  wire wr_speed = wr_ok & wr_port & (wr_idx_reg == `IDX_SPEED_FAULT);

  // axi slave
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      wr_idx_reg    <= 4'h0;
      wr_map_reg    <= 1'b0;
      wr_byte_reg   <= 8'h00;
      wr_lane_reg   <= 1'b0;
    end else begin
      aw_held_reg   <= aw_held_next;
      w_held_reg    <= w_held_next;
      s_axi_bvalid  <= bvalid_next;
      s_axi_rvalid  <= rvalid_next;
      // one write and one read in flight; ready drops while one is held
      s_axi_awready <= ~aw_held_next & ~bvalid_next;
      s_axi_wready  <= ~w_held_next & ~bvalid_next;
      s_axi_arready <= ~rvalid_next;
      if (aw_take) begin
        wr_idx_reg <= s_axi_awaddr[5:2];
        wr_map_reg <= addr_mapped(s_axi_awaddr);
      end
      if (w_take) begin
        wr_byte_reg <= s_axi_wdata[7:0];
        wr_lane_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bresp <= wr_map_reg ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (ar_take) begin
        s_axi_rresp <= addr_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // base select, per-port enables and validity windows
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_sel_reg    <= `PAGE_SEL_RST;
      port_sel_reg    <= `PORT_SEL_RST;
      port_disable    <= 3'h0;
      pie_reg         <= 3'h0;
      tree_valid_reg  <= 1'b0;
      speed_valid_reg <= 1'b0;
    end else begin
      // [R18] page select write
      // [R20] port select write
      if (wr_ok && (wr_idx_reg == `IDX_PAGE_PORT_SEL)) begin
        page_sel_reg <= wr_byte_reg[`SEL_PAGE_HI:`SEL_PAGE_LO];
        port_sel_reg <= wr_byte_reg[`SEL_PORT_HI:`SEL_PORT_LO];
      end
      // [R9] disable bit write
      if (wr_line) begin
        port_disable[wp] <= wr_byte_reg[`LS_DISABLE];
      end
      // [R12] event enable write
      if (wr_speed) begin
        pie_reg[wp] <= wr_byte_reg[`SF_EVENT_EN];
      end
      // [R5] child valid window
      tree_valid_reg  <= ~bus_reset & (tree_valid_reg | tree_id_done);
      // [R11] speed valid window
      speed_valid_reg <= ~bus_reset & (speed_valid_reg | self_id_done);
    end
  end

  // fault and port event flags; a new event beats a clear in the same cycle
  reg [2:0]  fault_next;
  reg        event_next;
  reg [11:0] status_now;
  integer    p;

  always @* begin
    fault_next = port_hold_suspend;
    event_next = port_event_flag;
    status_now = 12'h000;
    if (wr_ok && (wr_idx_reg == `IDX_EVENT_STATUS) &&
        wr_byte_reg[`EV_PORT_EVENT]) begin
      event_next = 1'b0;
    end
    for (p = 0; p < `PORT_COUNT; p = p + 1) begin
      status_now[p*4 +: 4] = {con_w[p], bias_w[p], port_disable[p],
                              port_hold_suspend[p]};
      // [R15] write one clears fault
      if (wr_speed && (wp == p) && wr_byte_reg[`SF_FAULT]) begin
        fault_next[p] = 1'b0;
      end
      // [R14] resume and suspend faults
      // [R13] fault holds suspend
      if ((resume_check[p] & ~bias_w[p]) |
          (suspend_check[p] & bias_w[p])) begin
        fault_next[p] = 1'b1;
      end
      // [R19] status change event
      // [R12] enabled event sets flag
      if (pie_reg[p] &&
          (status_now[p*4 +: 4] != prev_status_reg[p*4 +: 4])) begin
        event_next = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_hold_suspend <= 3'h0;
      port_event_flag   <= 1'b0;
      prev_status_reg   <= 12'h000;
    end else begin
      port_hold_suspend <= fault_next;
      port_event_flag   <= event_next;
      prev_status_reg   <= status_now;
    end
  end

  // read data selection
  reg [7:0] rd_byte;
  reg [1:0] rp;
  reg [2:0] spd;

  always @* begin
    rd_byte = 8'h00;
    rp      = port_sel_reg[1:0];
    spd     = peer_speed_raw[rp*3 +: 3];
    // [R10] clamp speeds above s400
    spd     = (spd > `SPEED_S400) ? `SPEED_S400 : spd;
    // [R11] invalid until self-id done
    spd     = speed_valid_reg ? spd : `SPEED_INVALID;
    case (s_axi_araddr[5:2])
      `IDX_EVENT_STATUS: rd_byte[`EV_PORT_EVENT] = port_event_flag;
      `IDX_PAGE_PORT_SEL: begin
        rd_byte[`SEL_PAGE_HI:`SEL_PAGE_LO] = page_sel_reg;
        rd_byte[`SEL_PORT_HI:`SEL_PORT_LO] = port_sel_reg;
      end
      default: rd_byte = 8'h00;
    endcase
    // [R2] unimplemented port reads zero
    if ((page_sel_reg == `PAGE_PORT_STATUS) && port_ok(port_sel_reg)) begin
      if (s_axi_araddr[5:2] == `IDX_LINE_STATUS) begin
        // [R3] pair a code
        rd_byte[`LS_PAIR_A_HI:`LS_PAIR_A_LO] =
          line_code(pair_a_valid[rp], pair_a_high_z[rp], pair_a_arb_bit[rp]);
        // [R4] pair b code
        rd_byte[`LS_PAIR_B_HI:`LS_PAIR_B_LO] =
          line_code(pair_b_valid[rp], pair_b_high_z[rp], pair_b_arb_bit[rp]);
        // [R5] idle ports read child
        rd_byte[`LS_CHILD] = child_raw[rp] | ~con_w[rp] | port_disable[rp] |
                             port_hold_suspend[rp] | ~tree_valid_reg;
        // [R7] attachment only
        rd_byte[`LS_CONNECTED] = con_w[rp];
        rd_byte[`LS_BIAS]      = bias_w[rp];
        rd_byte[`LS_DISABLE]   = port_disable[rp];
      end
      if (s_axi_araddr[5:2] == `IDX_SPEED_FAULT) begin
        rd_byte[`SF_SPEED_HI:`SF_SPEED_LO] = spd;
        rd_byte[`SF_EVENT_EN]              = pie_reg[rp];
        rd_byte[`SF_FAULT]                 = port_hold_suspend[rp];
      end
    end
    // [R17] identification page bytes
    // [R21] reserved addresses read zero
    if (page_sel_reg == `PAGE_IDENT) begin
      case (s_axi_araddr[5:2])
        `IDX_LINE_STATUS: rd_byte = `COMPLIANCE_LEVEL;
        `IDX_MAKER_HIGH:  rd_byte = MAKER_CODE[23:16];
        `IDX_MAKER_MID:   rd_byte = MAKER_CODE[15:8];
        `IDX_MAKER_LOW:   rd_byte = MAKER_CODE[7:0];
        `IDX_PART_HIGH:   rd_byte = PART_CODE[23:16];
        `IDX_PART_MID:    rd_byte = PART_CODE[15:8];
        `IDX_PART_LOW:    rd_byte = PART_CODE[7:0];
        default: rd_byte = rd_byte;
      endcase
    end
    if (!addr_mapped(s_axi_araddr)) begin
      rd_byte = 8'h00;
    end
  end

  // read data captured at the address handshake and held until taken
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rdata <= 32'h0000_0000;
    end else if (ar_take) begin
      s_axi_rdata <= {24'h00_0000, rd_byte};
    end
  end

endmodule
`default_nettype wire

// ==== hw/phy_port_status_pages_unused.v ====
// holds no logic; the port pages sit in phy_port_status_pages.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== verification/phy_port_pages_checker.sv ====
// assertions on the register bus and port control pins of the port pages.
// assumes it is bound into phy_port_status_pages and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module phy_port_pages_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // register bus
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  // port side
  input wire logic [2:0]  bias_raw,
  input wire logic [2:0]  resume_check,
  input wire logic [2:0]  port_disable,
  input wire logic [2:0]  port_hold_suspend,
  input wire logic        port_event_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  wire logic w_taken = s_axi_wvalid && s_axi_wready;
  wire logic r_taken = s_axi_arvalid && s_axi_arready;

  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && w_taken;
  endsequence
  sequence s_bias_low;
    !bias_raw[2] [*2];
  endsequence

  a_write_answer:
  assert property (s_write_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_unmapped_write:
  assert property (s_write_taken ##0 (s_axi_awaddr[31:6] != 26'h0 ||
    s_axi_awaddr[5:2] == 4'h6) |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  a_read_answer:
  assert property (r_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_unmapped_read:
  assert property (r_taken && s_axi_araddr[31:6] != 26'h0 |=>
    s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  a_reserved_zero:
  assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_resume_fault:
  assert property (s_bias_low ##0 resume_check[2] |=> port_hold_suspend[2])
    else $error("resume without bias not faulted");
  a_disable_by_write:
  assert property ($changed(port_disable) |-> $past(w_taken, 2))
    else $error("disable changed without write");
  a_fault_clear_write:
  assert property (|($past(port_hold_suspend) & ~port_hold_suspend) |->
    $past(w_taken, 2))
    else $error("fault cleared without write");
  a_event_clear_write:
  assert property ($fell(port_event_flag) |-> $past(w_taken, 2))
    else $error("event flag cleared without write");
endmodule

bind phy_port_status_pages phy_port_pages_checker u_phy_port_pages_checker (.*);

`default_nettype wire

// ==== verification/port_line_model.sv ====
// far side of the three cable ports: peer line drivers, attachment, bias.
// assumes the bench picks the symbols; outputs are what receivers would see.
`timescale 1ns/1ps
`default_nettype none

module port_line_model (
  // wanted symbol per port: 00 none, 01 one, 10 zero, 11 high-z
  input  wire logic [5:0] a_code,
  input  wire logic [5:0] b_code,
  // peer presence and peer bias drive
  input  wire logic [2:0] peer_attached,
  input  wire logic [2:0] peer_bias_on,
  // receiver side
  output var  logic [2:0] pair_a_valid,
  output var  logic [2:0] pair_a_high_z,
  output var  logic [2:0] pair_a_arb_bit,
  output var  logic [2:0] pair_b_valid,
  output var  logic [2:0] pair_b_high_z,
  output var  logic [2:0] pair_b_arb_bit,
  output wire logic [2:0] connect_raw,
  output wire logic [2:0] bias_raw
);
  // a dead line leaves both comparators high, so nothing may lean on them
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      pair_a_valid[p] = |a_code[2*p +: 2];
      pair_a_high_z[p] = ~^a_code[2*p +: 2];
      pair_a_arb_bit[p] = a_code[2*p +: 2] != 2'h2;
      pair_b_valid[p] = |b_code[2*p +: 2];
      pair_b_high_z[p] = ~^b_code[2*p +: 2];
      pair_b_arb_bit[p] = b_code[2*p +: 2] != 2'h2;
    end
  end
  assign connect_raw = peer_attached;
  // an absent or unpowered peer leaves the bias line pulled low
  assign bias_raw = peer_attached & peer_bias_on;
endmodule

`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the paged port status registers over axi4-lite.
// assumes the checker is bound in and the line model feeds the port pins.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // arbitrary identification values
  localparam logic [23:0] MAKER = 24'h5a_c3_17;
  localparam logic [23:0] PART = 24'h2e_91_b4;
  localparam logic [7:0] ID_TAB [8] = '{8'h01, 8'h00, MAKER[23:16],
    MAKER[15:8], MAKER[7:0], PART[23:16], PART[15:8], PART[7:0]};

  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdv;
  logic        bus_reset = 1'b0, tree_id_done = 1'b0, self_id_done = 1'b0;
  logic [2:0]  resume_check = 3'h0, suspend_check = 3'h0, child_raw = 3'h6;
  logic [8:0]  peer_speed_raw = 9'h0;
  logic [5:0]  a_code = 6'h3f, b_code = 6'h3f;
  logic [2:0]  peer_attached = 3'h0, peer_bias_on = 3'h0;
  logic [2:0]  pair_a_valid, pair_a_high_z, pair_a_arb_bit, pair_b_valid;
  logic [2:0]  pair_b_high_z, pair_b_arb_bit, connect_raw, bias_raw;
  logic [2:0]  port_disable, port_hold_suspend;
  logic        port_event_flag;
  int          errors = 0, num_checks = 0;

  always #10 clk = ~clk;

  phy_port_status_pages #(.CON_DEBOUNCE_CYCLES(25'd20), .MAKER_CODE(MAKER),
    .PART_CODE(PART)) u_phy_port_status_pages (.*);
  port_line_model u_port_line_model (.*);

  task automatic end_of_test();
    if (errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // address and data offered together; every channel held until taken
  task automatic bus(input logic wr, input logic [31:0] addr,
                     input logic [31:0] data);
    int n;
    @(posedge clk);
    if (wr) begin
      s_axi_awaddr <= addr;
      s_axi_wdata <= data;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= addr;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
        break;
      end
      if (s_axi_rready && s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        rsp = s_axi_rresp;
        rdv = s_axi_rdata;
        break;
      end
    end
    if (n == 50) begin
      errors++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    bus(1'b1, {26'h0, idx, 2'h0}, {24'h0, d});
  endtask

  task automatic rc(input logic [3:0] idx, input logic [7:0] e);
    bus(1'b0, {26'h0, idx, 2'h0}, 32'h0);
    chk(rdv, {24'h0, e});
  endtask

  // bits: suspend[8:6], resume[5:3], self-id, tree-id, bus reset
  task automatic pulse(input logic [8:0] m);
    @(posedge clk);
    {suspend_check, resume_check, self_id_done, tree_id_done, bus_reset} <= m;
    @(posedge clk);
    {suspend_check, resume_check, self_id_done, tree_id_done, bus_reset} <=
      9'h0;
    @(posedge clk);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    pulse(9'h004);
    rc(4'h7, 8'h00);
    wr(4'h7, 8'h20);
    for (int i = 0; i < 8; i++)
      rc(4'h8 + 4'(i), ID_TAB[i]);
    wr(4'h8, 8'hff);
    rc(4'h8, 8'h01);
    bus(1'b0, 32'h40, 32'h0);
    chk({30'h0, rsp}, 32'h2);
    chk(rdv, 32'h0);
    bus(1'b1, 32'h18, 32'h1);
    chk({30'h0, rsp}, 32'h2);
    wr(4'h7, 8'h03);
    wr(4'h8, 8'h01);
    rc(4'h8, 8'h00);
    rc(4'h9, 8'h00);
    chk({29'h0, port_disable}, 32'h0);
    wr(4'h7, 8'h01);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      a_code[3:2] <= 2'(i);
      b_code[3:2] <= 2'(3 - i);
      rc(4'h8, {2'(i), 2'(3 - i), 4'h8});
    end
    wr(4'h8, 8'h01);
    rc(4'h5, 8'h00);
    wr(4'h8, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'h9, 8'h10);
    wr(4'h8, 8'h01);
    // the flag rises one edge after the write lands
    @(posedge clk);
    chk({31'h0, port_event_flag}, 32'h1);
    chk({29'h0, port_disable}, 32'h1);
    rc(4'h5, 8'h01);
    wr(4'h5, 8'h01);
    rc(4'h5, 8'h00);
    pulse(9'h001);
    chk({29'h0, port_disable}, 32'h1);
    wr(4'h8, 8'h00);
    rc(4'h5, 8'h01);
    wr(4'h5, 8'h01);
    @(posedge clk);
    peer_attached <= 3'h1;
    peer_bias_on <= 3'h1;
    repeat (10) @(posedge clk);
    rc(4'h8, 8'hf8);
    repeat (40) @(posedge clk);
    rc(4'h8, 8'hfc);
    repeat (2100) @(posedge clk);
    rc(4'h8, 8'hfe);
    rc(4'h5, 8'h01);
    wr(4'h5, 8'h01);
    pulse(9'h002);
    rc(4'h8, 8'hf6);
    wr(4'h8, 8'h01);
    rc(4'h8, 8'hff);
    wr(4'h8, 8'h00);
    pulse(9'h001);
    rc(4'h8, 8'hfe);
    pulse(9'h002);
    rc(4'h8, 8'hf6);
    pulse(9'h001);
    rc(4'h9, 8'hf0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      peer_speed_raw[2:0] <= 3'(i);
      pulse(9'h004);
      rc(4'h9, {(i > 2) ? 3'h2 : 3'(i), 5'h10});
    end
    wr(4'h5, 8'h01);
    pulse(9'h040);
    chk({29'h0, port_hold_suspend}, 32'h1);
    rc(4'h9, 8'h58);
    rc(4'h5, 8'h01);
    wr(4'h9, 8'h10);
    rc(4'h9, 8'h58);
    pulse(9'h001);
    rc(4'h9, 8'hf8);
    pulse(9'h004);
    wr(4'h9, 8'h18);
    rc(4'h9, 8'h50);
    pulse(9'h088);
    chk({29'h0, port_hold_suspend}, 32'h0);
    pulse(9'h020);
    chk({29'h0, port_hold_suspend}, 32'h4);
    wr(4'h7, 8'h02);
    rc(4'h9, 8'h08);
    end_of_test();
  end
endmodule

`default_nettype wire
